// ===== rtl/dag_core.sv
// data address generation unit: forms data addresses and immediate operands
// assumes one decoder request per cycle; registers reached over a plain port
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module dag_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dag_pkg::dag_req_t req,
  output dag_pkg::dag_resp_t resp,
  input wire logic [dag_pkg::DAG_RA_W-1:0] reg_addr,
  input wire logic [dag_pkg::DAG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dag_pkg::DAG_DW-1:0] reg_rdata
);
  import dag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [DAG_PAGE_W-1:0] page_reg, page_next;
  logic [DAG_SEL_W-1:0] sel_reg, sel_next;
  logic [DAG_NPTR-1:0][DAG_DW-1:0] ptr_reg, ptr_next;
  logic [DAG_DW-1:0] cb1_start_reg, cb1_start_next;
  logic [DAG_DW-1:0] cb1_end_reg, cb1_end_next;
  logic [DAG_DW-1:0] cb2_start_reg, cb2_start_next;
  logic [DAG_DW-1:0] cb2_end_reg, cb2_end_next;
  logic [CB_CTRL_W-1:0] cb_ctrl_reg, cb_ctrl_next;
  logic [DAG_DW-1:0] status_reg, status_next;
  dag_resp_t resp_reg, resp_next;
  logic [DAG_DW-1:0] rdata_reg, rdata_next;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_ptr_addr(input logic [DAG_RA_W-1:0] a);
    return (a >= OFF_PTR0) && (a <= OFF_PTR7) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [DAG_SEL_W-1:0] ptr_index(input logic [DAG_RA_W-1:0] a);
    logic [DAG_RA_W-1:0] d;
    d = DAG_RA_W'(a - OFF_PTR0);
    return d[DAG_SEL_W+1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pointer selection and circular match

  logic [DAG_DW-1:0] cur_ptr;
  logic [DAG_DW-1:0] upd_ptr;
  logic cb1_hit, cb2_hit, circ_on, wrap_hit;
  logic [DAG_DW-1:0] circ_start, circ_end;

  assign cur_ptr = ptr_reg[sel_reg];

  // each buffer matched on its own
  assign cb1_hit = cb_ctrl_reg[CB1_EN_BIT]
                   && (cb_ctrl_reg[CB1_SEL_LSB +: DAG_SEL_W] == sel_reg);
  assign cb2_hit = cb_ctrl_reg[CB2_EN_BIT]
                   && (cb_ctrl_reg[CB2_SEL_LSB +: DAG_SEL_W] == sel_reg);
  assign circ_on = cb1_hit || cb2_hit;
  assign circ_start = cb1_hit ? cb1_start_reg : cb2_start_reg;
  assign circ_end = cb1_hit ? cb1_end_reg : cb2_end_reg;

  dag_ptr_calc #(
    .W(DAG_DW)
  ) u_ptr_calc (
    .ptr(cur_ptr),
    .index(ptr_reg[0]),
    .op(req.ind_op),
    .circ_on(circ_on),
    .circ_start(circ_start),
    .circ_end(circ_end),
    .ptr_new(upd_ptr),
    .wrapped(wrap_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next-state

  always_comb begin
    page_next = page_reg;
    sel_next = sel_reg;
    ptr_next = ptr_reg;
    cb1_start_next = cb1_start_reg;
    cb1_end_next = cb1_end_reg;
    cb2_start_next = cb2_start_reg;
    cb2_end_next = cb2_end_reg;
    cb_ctrl_next = cb_ctrl_reg;
    status_next = status_reg;
    resp_next = '0;
    rdata_next = RST_WORD;

    if (req.valid) begin
      status_next[ST_MODE_LSB +: 3] = req.mode;
      case (req.mode)
        MODE_DIRECT: begin
          resp_next.addr_valid = 1'b1;
          resp_next.addr = {page_reg, req.dir_offset};
        end
        MODE_INDIRECT: begin
          resp_next.addr_valid = 1'b1;
          resp_next.addr = cur_ptr;
          ptr_next[sel_reg] = upd_ptr;
          if (req.sel_load) begin
            sel_next = req.sel_value;
          end
          resp_next.wrapped = wrap_hit;
          status_next[ST_WRAP1_BIT] = wrap_hit && cb1_hit;
          status_next[ST_WRAP2_BIT] = wrap_hit && !cb1_hit;
        end
        MODE_SHORT_IMM: begin
          resp_next.opnd_valid = 1'b1;
          resp_next.opnd = DAG_DW'(req.short_imm);
        end
        MODE_LONG_IMM: begin
          resp_next.opnd_valid = 1'b1;
          resp_next.opnd = req.long_word;
        end
        MODE_REGISTER: begin
          resp_next.opnd_valid = 1'b1;
          resp_next.opnd = req.reg_value;
        end
        MODE_MMAP: begin
          resp_next.addr_valid = 1'b1;
          resp_next.addr = {{DAG_PAGE_W{1'b0}}, req.dir_offset};
        end
        default: begin
          resp_next = '0;
        end
      endcase
    end

    // software write lands after any addressing update
    if (reg_wr) begin
      if (is_ptr_addr(reg_addr)) begin
        ptr_next[ptr_index(reg_addr)] = reg_wdata;
      end else begin
        case (reg_addr)
          OFF_PAGE: page_next = reg_wdata[DAG_PAGE_W-1:0];
          OFF_SEL: sel_next = reg_wdata[DAG_SEL_W-1:0];
          OFF_CB1_START: cb1_start_next = reg_wdata;
          OFF_CB1_END: cb1_end_next = reg_wdata;
          OFF_CB2_START: cb2_start_next = reg_wdata;
          OFF_CB2_END: cb2_end_next = reg_wdata;
          OFF_CB_CTRL: cb_ctrl_next = reg_wdata[CB_CTRL_W-1:0];
          default: begin
            cb_ctrl_next = cb_ctrl_next;
          end
        endcase
      end
    end

    if (reg_rd) begin
      if (is_ptr_addr(reg_addr)) begin
        rdata_next = ptr_reg[ptr_index(reg_addr)];
      end else begin
        case (reg_addr)
          OFF_PAGE: rdata_next = DAG_DW'(page_reg);
          OFF_SEL: rdata_next = DAG_DW'(sel_reg);
          OFF_CB1_START: rdata_next = cb1_start_reg;
          OFF_CB1_END: rdata_next = cb1_end_reg;
          OFF_CB2_START: rdata_next = cb2_start_reg;
          OFF_CB2_END: rdata_next = cb2_end_reg;
          OFF_CB_CTRL: rdata_next = DAG_DW'(cb_ctrl_reg);
          OFF_STATUS: rdata_next = status_reg;
          default: rdata_next = RST_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      page_reg <= RST_PAGE;
      sel_reg <= RST_SEL;
      ptr_reg <= {DAG_NPTR{RST_PTR}};
      cb1_start_reg <= RST_CB;
      cb1_end_reg <= RST_CB;
      cb2_start_reg <= RST_CB;
      cb2_end_reg <= RST_CB;
      cb_ctrl_reg <= RST_CB_CTRL;
      status_reg <= RST_WORD;
      resp_reg <= '0;
      rdata_reg <= RST_WORD;
    end else begin
      page_reg <= page_next;
      sel_reg <= sel_next;
      ptr_reg <= ptr_next;
      cb1_start_reg <= cb1_start_next;
      cb1_end_reg <= cb1_end_next;
      cb2_start_reg <= cb2_start_next;
      cb2_end_reg <= cb2_end_next;
      cb_ctrl_reg <= cb_ctrl_next;
      status_reg <= status_next;
      resp_reg <= resp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign resp = resp_reg;
  assign reg_rdata = rdata_reg;

endmodule

// ===== rtl/dag_pkg.sv
// data address generation unit: shared types, register offsets and reset values
// assumes a 16-bit data path and a single core clock
package dag_pkg;

  localparam int DAG_DW = 16;
  localparam int DAG_PAGE_W = 9;
  localparam int DAG_OFS_W = 7;
  localparam int DAG_NPTR = 8;
  localparam int DAG_SEL_W = 3;
  localparam int DAG_SIMM_W = 13;
  localparam int DAG_RA_W = 8;

  // register offsets, byte addresses, one 16-bit register per word
  localparam logic [7:0] OFF_PAGE = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_PTR0 = 8'h08;
  localparam logic [7:0] OFF_PTR7 = 8'h24;
  localparam logic [7:0] OFF_CB1_START = 8'h28;
  localparam logic [7:0] OFF_CB1_END = 8'h2C;
  localparam logic [7:0] OFF_CB2_START = 8'h30;
  localparam logic [7:0] OFF_CB2_END = 8'h34;
  localparam logic [7:0] OFF_CB_CTRL = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;

  // circular control field positions
  localparam int CB1_SEL_LSB = 0;
  localparam int CB1_EN_BIT = 3;
  localparam int CB2_SEL_LSB = 4;
  localparam int CB2_EN_BIT = 7;
  localparam int CB_CTRL_W = 8;

  // status field positions
  localparam int ST_WRAP1_BIT = 0;
  localparam int ST_WRAP2_BIT = 1;
  localparam int ST_MODE_LSB = 4;

  // reset values
  localparam logic [8:0] RST_PAGE = 9'h000;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [15:0] RST_CB = 16'h0000;
  localparam logic [7:0] RST_CB_CTRL = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_SHORT_IMM,
    MODE_LONG_IMM,
    MODE_REGISTER,
    MODE_MMAP
  } dag_mode_t;

  typedef enum logic [2:0] {
    IND_INC,
    IND_DEC,
    IND_ADD_IDX,
    IND_SUB_IDX,
    IND_NONE,
    IND_BR_INC,
    IND_BR_DEC
  } dag_ind_op_t;

  typedef struct packed {
    logic valid;
    dag_mode_t mode;
    logic [DAG_OFS_W-1:0] dir_offset;
    dag_ind_op_t ind_op;
    logic sel_load;
    logic [DAG_SEL_W-1:0] sel_value;
    logic [DAG_SIMM_W-1:0] short_imm;
    logic [DAG_DW-1:0] long_word;
    logic [DAG_DW-1:0] reg_value;
  } dag_req_t;

  typedef struct packed {
    logic addr_valid;
    logic [DAG_DW-1:0] addr;
    logic opnd_valid;
    logic [DAG_DW-1:0] opnd;
    logic wrapped;
  } dag_resp_t;

  function automatic logic [DAG_DW-1:0] dag_bitrev(input logic [DAG_DW-1:0] v);
    logic [DAG_DW-1:0] r;
    r = '0;
    for (int i = 0; i < DAG_DW; i++) begin
      r[i] = v[DAG_DW-1-i];
    end
    return r;
  endfunction

endpackage

// ===== rtl/dag_ptr_calc.sv
// pointer modification for indirect addressing, with circular wrap
// assumes start and end values were loaded by software beforehand
`timescale 1ns/1ps
module dag_ptr_calc #(
  parameter int W = 16
) (
  input wire logic [W-1:0] ptr,
  input wire logic [W-1:0] index,
  input wire dag_pkg::dag_ind_op_t op,
  input wire logic circ_on,
  input wire logic [W-1:0] circ_start,
  input wire logic [W-1:0] circ_end,
  output logic [W-1:0] ptr_new,
  output logic wrapped
);
  import dag_pkg::*;

  logic [W-1:0] step;

  always_comb begin
    case (op)
      IND_INC: step = W'(ptr + W'(1));
      IND_DEC: step = W'(ptr - W'(1));
      IND_ADD_IDX: step = W'(ptr + index);
      IND_SUB_IDX: step = W'(ptr - index);
      IND_BR_INC: step = dag_bitrev(W'(dag_bitrev(ptr) + dag_bitrev(index)));
      IND_BR_DEC: step = dag_bitrev(W'(dag_bitrev(ptr) - dag_bitrev(index)));
      default: step = ptr;
    endcase
    wrapped = circ_on && (op != IND_NONE) && (ptr == circ_end);
    ptr_new = wrapped ? circ_start : step;
  end

endmodule

// ===== tb/dag_chk.sv
// concurrent checks on the dag_core ports
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
module dag_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dag_pkg::dag_req_t req,
  input wire dag_pkg::dag_resp_t resp,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  import dag_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic v;
  logic ind;
  assign v = req.valid;
  assign ind = v && req.mode == MODE_INDIRECT;
  idle_zero_a: assert property ($past(rst_n) && !$past(v) |-> resp == '0)
    else $error("resp not zero after idle cycle");
  direct_addr_a: assert property (v && req.mode == MODE_DIRECT |=> resp.addr_valid
    && !resp.opnd_valid && resp.addr[6:0] == $past(req.dir_offset))
    else $error("direct address wrong");
  mmap_page_a: assert property (v && req.mode == MODE_MMAP |=> resp.addr_valid
    && resp.addr == {9'h000, $past(req.dir_offset)}) else $error("mapped address wrong");
  short_imm_a: assert property (v && req.mode == MODE_SHORT_IMM |=> resp.opnd_valid
    && !resp.addr_valid && resp.opnd == {3'h0, $past(req.short_imm)})
    else $error("short operand wrong");
  long_imm_a: assert property (v && req.mode == MODE_LONG_IMM |=> resp.opnd_valid
    && resp.opnd == $past(req.long_word)) else $error("long operand wrong");
  reg_opnd_a: assert property (v && req.mode == MODE_REGISTER |=> !resp.addr_valid
    && resp.opnd == $past(req.reg_value)) else $error("register operand wrong");
  inc_step_a: assert property (ind && req.ind_op == IND_INC && !req.sel_load && !reg_wr
    ##1 ind && !reg_wr && !resp.wrapped |=> resp.addr == $past(resp.addr) + 16'h0001)
    else $error("pointer did not step by one");
  wrap_cause_a: assert property (resp.wrapped |->
    $past(ind && req.ind_op != IND_NONE)) else $error("wrap without indirect step");
  rdata_idle_a: assert property ($past(rst_n) && !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
endmodule

// ===== tb/dag_mem_model.sv
// data memory side: takes each formed address
// assumes resp fields stand one cycle
`timescale 1ns/1ps
module dag_mem_model (
  input wire logic core_clk,
  input wire dag_pkg::dag_resp_t resp
);
  int n_acc = 0;
  logic [15:0] last_addr = '0;
  always @(posedge core_clk) begin
    if (resp.addr_valid) begin
      n_acc <= n_acc + 1;
      last_addr <= resp.addr;
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for dag_core against a queue-free reference model
// assumes the checker and memory model files are compiled first
`timescale 1ns/1ps
module testbench;
  import dag_pkg::*;
  logic core_clk = 0;
  logic rst_n = 0;
  dag_req_t req = '0;
  dag_resp_t resp;
  dag_resp_t pend = '0;
  logic [7:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [15:0] reg_rdata;
  logic [15:0] prd = '0;
  int n_errors = 0;
  int check_count = 0;
  logic [8:0] m_page = '0;
  logic [2:0] m_sel = '0;
  logic [15:0] m_ptr [8] = '{default: '0};
  logic [15:0] m_cb [4] = '{default: '0};
  logic [7:0] m_ctl = '0;
  logic [15:0] m_st = '0;
  logic [15:0] m_last = '0;
  int m_acc = 0;
  always #2.5 core_clk = ~core_clk;
  dag_core dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .resp(resp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  dag_mem_model u_mem (.core_clk(core_clk), .resp(resp));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rev(input logic [15:0] a);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15-i];
    end
    return r;
  endfunction
  function automatic logic [15:0] m_read(input logic [7:0] a);
    if (a == OFF_PAGE) return {7'h00, m_page};
    if (a == OFF_SEL) return {13'h0000, m_sel};
    if (a >= OFF_PTR0 && a <= OFF_PTR7) return m_ptr[(a - OFF_PTR0) >> 2];
    if (a >= OFF_CB1_START && a <= OFF_CB2_END) return m_cb[(a - OFF_CB1_START) >> 2];
    if (a == OFF_CB_CTRL) return {8'h00, m_ctl};
    if (a == OFF_STATUS) return m_st;
    return 16'h0000;
  endfunction
  task automatic m_write(input logic [7:0] a, input logic [15:0] d);
    if (a == OFF_PAGE) m_page = d[8:0];
    if (a == OFF_SEL) m_sel = d[2:0];
    if (a >= OFF_PTR0 && a <= OFF_PTR7) m_ptr[(a - OFF_PTR0) >> 2] = d;
    if (a >= OFF_CB1_START && a <= OFF_CB2_END) m_cb[(a - OFF_CB1_START) >> 2] = d;
    if (a == OFF_CB_CTRL) m_ctl = d[7:0];
  endtask
  task automatic m_req(input dag_req_t r, output dag_resp_t e);
    logic [15:0] p;
    logic [15:0] n;
    logic [15:0] x;
    int b;
    e = '0;
    p = m_ptr[m_sel];
    x = m_ptr[0];
    if (!r.valid) return;
    m_st[ST_MODE_LSB +: 3] = r.mode;
    case (r.mode)
      MODE_DIRECT: e.addr = {m_page, r.dir_offset};
      MODE_MMAP: e.addr = {9'h000, r.dir_offset};
      MODE_INDIRECT: e.addr = p;
      MODE_SHORT_IMM: e.opnd = {3'h0, r.short_imm};
      MODE_LONG_IMM: e.opnd = r.long_word;
      MODE_REGISTER: e.opnd = r.reg_value;
      default: e = '0;
    endcase
    e.addr_valid = r.mode inside {MODE_DIRECT, MODE_MMAP, MODE_INDIRECT};
    e.opnd_valid = r.mode inside {MODE_SHORT_IMM, MODE_LONG_IMM, MODE_REGISTER};
    if (r.mode != MODE_INDIRECT) return;
    case (r.ind_op)
      IND_INC: n = p + 16'h0001;
      IND_DEC: n = p - 16'h0001;
      IND_ADD_IDX: n = p + x;
      IND_SUB_IDX: n = p - x;
      IND_BR_INC: n = rev(rev(p) + rev(x));
      IND_BR_DEC: n = rev(rev(p) - rev(x));
      default: n = p;
    endcase
    b = (m_ctl[3] && m_ctl[2:0] == m_sel) ? 0 : (m_ctl[7] && m_ctl[6:4] == m_sel) ? 2 : -1;
    if (b >= 0 && r.ind_op != IND_NONE && p == m_cb[b+1]) begin
      n = m_cb[b];
      e.wrapped = 1'b1;
    end
    // last indirect wrap, per buffer
    m_st[ST_WRAP1_BIT] = e.wrapped && b == 0;
    m_st[ST_WRAP2_BIT] = e.wrapped && b == 2;
    m_ptr[m_sel] = n;
    if (r.sel_load) m_sel = r.sel_value;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [63:0] x, input logic [63:0] g);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic cyc(input dag_req_t r, input logic w, input logic rd, input logic [7:0] a,
    input logic [15:0] d);
    dag_resp_t e;
    @(posedge core_clk);
    req <= r;
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    #1;
    chk("resp", {11'h0, pend}, {11'h0, resp});
    chk("reg_rdata", {48'h0, prd}, {48'h0, reg_rdata});
    if (pend.addr_valid) begin
      m_acc++;
      m_last = pend.addr;
    end
    m_req(r, e);
    pend = e;
    prd = rd ? m_read(a) : 16'h0000;
    if (w) m_write(a, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cyc('0, 1'b1, 1'b0, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    cyc('0, 1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic rq(input int m, input int op, input logic sl, input logic [2:0] sv);
    logic [63:0] x;
    dag_req_t r;
    x = {$urandom, $urandom};
    r = x[$bits(dag_req_t)-1:0];
    r.valid = 1'b1;
    r.mode = dag_mode_t'(3'(m));
    r.ind_op = dag_ind_op_t'(3'(op));
    r.sel_load = sl;
    r.sel_value = sv;
    cyc(r, 1'b0, 1'b0, 8'h00, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(41));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 'h3C; a += 4) rdr(8'(a));
    wr(8'hFC, 16'hFFFF);
    rdr(8'hFC);
    rdr(8'h40);
    $display("test reset_map done");
    wr(OFF_PAGE, 16'($urandom));
    for (int i = 0; i < 8; i++) wr(8'(OFF_PTR0 + 4 * i), 16'($urandom));
    for (int i = 0; i < 72; i++) rq(i < 8 ? i : $urandom_range(0, 7),
      i % 7, 1'($urandom), 3'($urandom));
    $display("test modes done");
    wr(OFF_PTR0 + 8'h08, 16'h0100);
    wr(OFF_PTR0 + 8'h14, 16'h0200);
    wr(OFF_CB1_START, 16'h0100);
    wr(OFF_CB1_END, 16'h0103);
    wr(OFF_CB2_START, 16'h0200);
    wr(OFF_CB2_END, 16'h0202);
    wr(OFF_CB_CTRL, 16'h00DA);
    wr(OFF_SEL, 16'h0002);
    // buffer 1 wraps at step 6, buffer 2 at step 17
    for (int i = 0; i < 18; i++) begin
      rq(1, 0, 1'b1, i[0] ? 3'h2 : 3'h5);
      if (i == 6 || i == 17) rdr(OFF_STATUS);
    end
    for (int i = 0; i < 40; i++) rq(1, $urandom_range(0, 6), 1'($urandom), 3'($urandom));
    $display("test circular done");
    for (int a = 0; a <= 'h3C; a += 4) rdr(8'(a));
    cyc('0, 1'b0, 1'b0, 8'h00, 16'h0000);
    chk("mem_accesses", 64'(m_acc), 64'(u_mem.n_acc));
    chk("mem_last_addr", 64'(m_last), 64'(u_mem.last_addr));
    $display("test readback done");
    test_done();
  end
endmodule
bind dag_core dag_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .req(req), .resp(resp),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
